// ==== csi_defines.vh ====
/*
  Constants of the special function register and interrupt block:
  register offsets, field positions, reset values and vectors.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CSI_DEFINES_VH
`define CSI_DEFINES_VH

// --------------------------------------------------------------
// Register offsets (data memory addresses)
// --------------------------------------------------------------
`define CSI_ADDR_WIN_A 8'h00
`define CSI_ADDR_PTR_A 8'h01
`define CSI_ADDR_WIN_B 8'h02
`define CSI_ADDR_PTR_B 8'h03
`define CSI_ADDR_WORK 8'h05
`define CSI_ADDR_FLAG 8'h0a
`define CSI_ADDR_IRQ_A 8'h0b
`define CSI_ADDR_IRQ_B 8'h1e
`define CSI_RAM_BASE 8'h40

// --------------------------------------------------------------
// Flag register fields
// --------------------------------------------------------------
`define CSI_F_SUM 0
`define CSI_F_HALF 1
`define CSI_F_NULL 2
`define CSI_F_WRAP 3
`define CSI_F_SLEEP 4
`define CSI_F_WDOG 5
`define CSI_FLAG_ARITH_MASK 8'h0f

// --------------------------------------------------------------
// Interrupt control fields
// --------------------------------------------------------------
`define CSI_A_GIE 0
`define CSI_A_MASK 8'h7f
`define CSI_B_MASK 8'h77
`define CSI_FLAG_LSB 4

// --------------------------------------------------------------
// ALU operation codes
// --------------------------------------------------------------
`define CSI_ALU_ADD 3'h0
`define CSI_ALU_SUB 3'h1
`define CSI_ALU_LOGIC 3'h2
`define CSI_ALU_RRC 3'h3
`define CSI_ALU_RLC 3'h4

// --------------------------------------------------------------
// Vectors and reset values
// --------------------------------------------------------------
`define CSI_VEC_STEP 12'h004
`define CSI_RST_BYTE 8'h00

`endif

// ==== csi_ram.v ====
/*
  General purpose data RAM, one write port, registered read data.
  Assumes a single clock; contents are not reset.
*/
`timescale 1ns/1ps
module csi_ram #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------------------------
  // Storage
  // ----------------------------------------------------------
  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ==== csi_core_sfr.v ====
/*
  Special function registers, indirect windows and interrupt controller
  of an 8-bit core, reached over APB and from the core sequencer.
  Assumes core strobes and peripheral events are one-cycle pulses
  synchronous to pclk.
*/
`timescale 1ns/1ps
`include "csi_defines.vh"
module csi_core_sfr #(
  parameter NSRC = 6
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire alu_valid,
  input wire [2:0] alu_op,
  input wire [7:0] alu_a,
  input wire [7:0] alu_b,
  input wire alu_cin,
  input wire alu_write_work,
  output reg [7:0] alu_result,
  input wire sleep_instruction,
  input wire watchdog_kick_op,
  input wire watchdog_timeout,
  input wire irq_exit_op,
  input wire sub_exit_op,
  input wire stack_full,
  input wire irq_accept,
  output wire irq_request,
  output reg [11:0] irq_vector,
  output wire wake_up,
  input wire ext_irq_pin,
  input wire tmr_a_overflow,
  input wire tmr_b_overflow,
  input wire usb_fifo_access,
  input wire usb_suspend,
  input wire usb_resume,
  input wire usb_bus_reset,
  input wire serial_a_done,
  input wire serial_b_done
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  reg [7:0] ram_pointer_a;
  reg [7:0] ram_pointer_b;
  reg [7:0] work_register;
  reg [3:0] arith_flags;
  reg sleep_entered_flag;
  reg watchdog_expired_flag;
  reg global_irq_enable;
  reg [NSRC-1:0] irq_enable;
  reg [NSRC-1:0] irq_flag;
  reg ext_pin_q;
  reg phase;
  reg [7:0] next_result;
  reg [3:0] next_arith;
  reg [8:0] sum9;
  reg [4:0] sum5;
  reg [7:0] sum7;
  reg [7:0] eff_addr;
  reg [7:0] rd_byte;
  reg [7:0] sfr_rd;
  reg [2:0] src_idx;
  reg [NSRC-1:0] pend;
  integer i;

  wire [7:0] addr = paddr[9:2];
  wire acc = psel & penable;
  wire wr_done = acc & pwrite;
  wire [7:0] wbyte = pwdata[7:0];
  wire [7:0] flag_register = {2'b00, watchdog_expired_flag, sleep_entered_flag, arith_flags};
  wire [7:0] irq_ctrl_reg_a = {1'b0, irq_flag[2:0], irq_enable[2:0], global_irq_enable};
  wire [7:0] irq_ctrl_reg_b = {1'b0, irq_flag[5:3], 1'b0, irq_enable[5:3]};

  // ----------------------------------------------------------
  // Address resolution
  // ----------------------------------------------------------
  function is_window;
    input [7:0] a;
    begin
      is_window = (a == `CSI_ADDR_WIN_A) || (a == `CSI_ADDR_WIN_B);
    end
  endfunction

  always @*
  begin
    if (addr == `CSI_ADDR_WIN_A)
    begin
      eff_addr = ram_pointer_a;
    end
    else if (addr == `CSI_ADDR_WIN_B)
    begin
      eff_addr = ram_pointer_b;
    end
    else
    begin
      eff_addr = addr;
    end
  end

  wire indirect = is_window(addr);
  wire to_window = indirect & is_window(eff_addr);
  wire ram_sel = (eff_addr >= `CSI_RAM_BASE) & ~to_window;
  wire sfr_wr = wr_done & ~to_window;

  always @*
  begin
    case (eff_addr)
      `CSI_ADDR_PTR_A: sfr_rd = ram_pointer_a;
      `CSI_ADDR_PTR_B: sfr_rd = ram_pointer_b;
      `CSI_ADDR_WORK: sfr_rd = work_register;
      `CSI_ADDR_FLAG: sfr_rd = flag_register;
      `CSI_ADDR_IRQ_A: sfr_rd = irq_ctrl_reg_a & `CSI_A_MASK;
      `CSI_ADDR_IRQ_B: sfr_rd = irq_ctrl_reg_b & `CSI_B_MASK;
      default: sfr_rd = 8'h00;
    endcase
  end

  // Two-phase access: first access cycle reads RAM, second completes
  assign pready = phase;
  assign pslverr = 1'b0;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 1'b0;
    end
    else
    begin
      phase <= acc & ~phase;
    end
  end

  csi_ram #(
    .AW(8),
    .DW(8)
  ) u_ram (
    .clk(pclk),
    .we(wr_done & phase & ram_sel),
    .waddr(eff_addr),
    .wdata(wbyte),
    .raddr(eff_addr),
    .rdata(rd_byte)
  );

  // ----------------------------------------------------------
  // ALU flag evaluation
  // ----------------------------------------------------------
  always @*
  begin
    sum9 = 9'h000;
    sum5 = 5'h00;
    sum7 = 8'h00;
    next_result = alu_a;
    next_arith = arith_flags;
    case (alu_op)
      `CSI_ALU_ADD:
      begin
        sum9 = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
        sum5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, alu_cin};
        sum7 = {1'b0, alu_a[6:0]} + {1'b0, alu_b[6:0]} + {7'h00, alu_cin};
        next_result = sum9[7:0];
        next_arith[`CSI_F_SUM] = sum9[8];
        next_arith[`CSI_F_HALF] = sum5[4];
        next_arith[`CSI_F_WRAP] = sum7[7] ^ sum9[8];
      end
      `CSI_ALU_SUB:
      begin
        sum9 = {1'b0, alu_a} + {1'b0, ~alu_b} + {8'h00, alu_cin};
        sum5 = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + {4'h0, alu_cin};
        sum7 = {1'b0, alu_a[6:0]} + {1'b0, ~alu_b[6:0]} + {7'h00, alu_cin};
        next_result = sum9[7:0];
        next_arith[`CSI_F_SUM] = sum9[8];
        next_arith[`CSI_F_HALF] = sum5[4];
        next_arith[`CSI_F_WRAP] = sum7[7] ^ sum9[8];
      end
      `CSI_ALU_LOGIC:
      begin
        next_result = alu_b;
      end
      `CSI_ALU_RRC:
      begin
        next_result = {arith_flags[`CSI_F_SUM], alu_a[7:1]};
        next_arith[`CSI_F_SUM] = alu_a[0];
      end
      `CSI_ALU_RLC:
      begin
        next_result = {alu_a[6:0], arith_flags[`CSI_F_SUM]};
        next_arith[`CSI_F_SUM] = alu_a[7];
      end
      default:
      begin
        next_result = alu_a;
      end
    endcase
    if (alu_op != `CSI_ALU_RRC && alu_op != `CSI_ALU_RLC)
    begin
      next_arith[`CSI_F_NULL] = (next_result == 8'h00);
    end
  end

  // ----------------------------------------------------------
  // Interrupt selection
  // ----------------------------------------------------------
  always @*
  begin
    pend = irq_flag & irq_enable;
    src_idx = 3'd0;
    for (i = NSRC - 1; i >= 0; i = i - 1)
    begin
      if (pend[i])
      begin
        src_idx = i[2:0];
      end
    end
  end

  assign irq_request = global_irq_enable & ~stack_full & (|pend);
  assign wake_up = |irq_flag;

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  wire ext_fall = ext_pin_q & ~ext_irq_pin;
  wire [NSRC-1:0] events = {serial_b_done, serial_a_done,
    usb_fifo_access | usb_suspend | usb_resume | usb_bus_reset,
    tmr_b_overflow, tmr_a_overflow, ext_fall};
  wire take = irq_accept & irq_request;
  reg [NSRC-1:0] clr_mask;
  reg [NSRC-1:0] next_flag;
  reg [NSRC-1:0] wr_flag;

  always @*
  begin
    clr_mask = {NSRC{1'b0}};
    if (take)
    begin
      clr_mask[src_idx] = 1'b1;
    end
    wr_flag = irq_flag;
    if (sfr_wr && phase && eff_addr == `CSI_ADDR_IRQ_A)
    begin
      wr_flag[2:0] = wbyte[6:4];
    end
    if (sfr_wr && phase && eff_addr == `CSI_ADDR_IRQ_B)
    begin
      wr_flag[5:3] = wbyte[6:4];
    end
    // Event set wins over software or acceptance clear
    next_flag = (wr_flag & ~clr_mask) | events;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ram_pointer_a <= `CSI_RST_BYTE;
      ram_pointer_b <= `CSI_RST_BYTE;
      work_register <= `CSI_RST_BYTE;
      arith_flags <= 4'h0;
      sleep_entered_flag <= 1'b0;
      watchdog_expired_flag <= 1'b0;
      global_irq_enable <= 1'b0;
      irq_enable <= {NSRC{1'b0}};
      irq_flag <= {NSRC{1'b0}};
      ext_pin_q <= 1'b1;
      alu_result <= `CSI_RST_BYTE;
      irq_vector <= 12'h000;
      prdata <= 32'h00000000;
    end
    else
    begin
      ext_pin_q <= ext_irq_pin;
      irq_flag <= next_flag;
      if (alu_valid)
      begin
        alu_result <= next_result;
        arith_flags <= next_arith;
        if (alu_write_work)
        begin
          work_register <= next_result;
        end
      end
      if (sleep_instruction)
      begin
        sleep_entered_flag <= 1'b1;
        watchdog_expired_flag <= 1'b0;
      end
      else if (watchdog_kick_op)
      begin
        sleep_entered_flag <= 1'b0;
        watchdog_expired_flag <= 1'b0;
      end
      if (watchdog_timeout)
      begin
        watchdog_expired_flag <= 1'b1;
      end
      if (sfr_wr && phase)
      begin
        case (eff_addr)
          `CSI_ADDR_PTR_A: ram_pointer_a <= wbyte;
          `CSI_ADDR_PTR_B: ram_pointer_b <= wbyte;
          `CSI_ADDR_WORK: work_register <= wbyte;
          `CSI_ADDR_FLAG: arith_flags <= wbyte[3:0];
          `CSI_ADDR_IRQ_A:
          begin
            global_irq_enable <= wbyte[`CSI_A_GIE];
            irq_enable[2:0] <= wbyte[3:1];
          end
          `CSI_ADDR_IRQ_B: irq_enable[5:3] <= wbyte[2:0];
          default: ;
        endcase
      end
      if (take)
      begin
        global_irq_enable <= 1'b0;
        irq_vector <= `CSI_VEC_STEP * ({9'h000, src_idx} + 12'h001);
      end
      else if (irq_exit_op)
      begin
        global_irq_enable <= 1'b1;
      end
      // Read data loaded so it stands through the ready cycle
      if (acc && !phase && !pwrite)
      begin
        prdata <= {24'h000000, ram_sel ? rd_byte : sfr_rd};
      end
    end
  end
endmodule

// ==== csi_core_model.sv ====
/*
  Core sequencer model: takes a pending interrupt after a set stall.
  Assumes irq_request is a level from the block on the same pclk.
*/
`timescale 1ns/1ps
module csi_core_model (
  input wire pclk,
  input wire presetn,
  input wire irq_request,
  input wire [3:0] stall,
  output reg irq_accept
);
  reg [3:0] wait_cnt;
  // ----
  // Accept pulse after stall+1 cycles of pending request
  // ----
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_accept <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (irq_accept || !irq_request)
    begin
      irq_accept <= 1'b0;
      wait_cnt <= 4'h0;
    end
    else if (wait_cnt == stall)
      irq_accept <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

// ==== csi_core_sfr_sva.sv ====
/*
  Port checker of csi_core_sfr: APB wait state and interrupt taking.
  Assumes the single clock pclk and reset presetn of the block.
*/
`timescale 1ns/1ps
module csi_core_sfr_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire stack_full,
  input wire irq_accept,
  input wire irq_request,
  input wire [11:0] irq_vector,
  input wire wake_up
);
  wire take = irq_accept && irq_request;
  wire wr_done = pready && pwrite;
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // Checks
  // ----
  apb_wait_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_idle_a: assert property (!psel |-> !pready)
    else $error("pready without select");
  stack_block_a: assert property (stack_full |-> !irq_request)
    else $error("request while stack full");
  wake_req_a: assert property (irq_request |-> wake_up)
    else $error("request without wake");
  take_block_a: assert property (take && !wr_done |=> !irq_request)
    else $error("request right after take");
  vec_set_a: assert property (take |=> irq_vector inside {12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018})
    else $error("bad vector after take");
  vec_stay_a: assert property (!take |=> $stable(irq_vector))
    else $error("vector moved without take");
  wake_keep_a: assert property (wake_up && !take && !wr_done |=> wake_up)
    else $error("wake dropped without cause");
  take_cv: cover property (take);
  full_cv: cover property (stack_full && wake_up);
  read_cv: cover property (pready && !pwrite);
endmodule
bind csi_core_sfr csi_core_sfr_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .stack_full(stack_full), .irq_accept(irq_accept),
  .irq_request(irq_request), .irq_vector(irq_vector), .wake_up(wake_up));

// ==== core_sfr_interrupt_control_tb.sv ====
/*
  Self-checking bench of csi_core_sfr with the core model.
  Assumes design, model and checker files compiled before it.
*/
`timescale 1ns/1ps
`include "csi_defines.vh"
module core_sfr_interrupt_control_tb;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] paddr = 32'h0;
  reg [31:0] pwdata = 32'h0;
  reg alu_valid = 1'b0;
  reg alu_cin = 1'b0;
  reg alu_write_work = 1'b0;
  reg [2:0] alu_op = 3'h0;
  reg [7:0] alu_a = 8'h00;
  reg [7:0] alu_b = 8'h00;
  reg stack_full = 1'b0;
  reg ext_irq_pin = 1'b1;
  reg [3:0] stall = 4'h0;
  reg [12:0] pl = 13'h0;
  reg [7:0] rd;
  reg [31:0] rows [0:10];
  wire [31:0] prdata;
  wire [7:0] alu_result;
  wire [11:0] irq_vector;
  wire pready, pslverr, irq_accept, irq_request, wake_up;
  integer error_cnt = 0;
  integer tests_run = 0;
  integer i, n;
  csi_core_sfr i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_cin(alu_cin),
    .alu_write_work(alu_write_work), .alu_result(alu_result), .sleep_instruction(pl[8]),
    .watchdog_kick_op(pl[9]), .watchdog_timeout(pl[10]), .irq_exit_op(pl[11]), .sub_exit_op(pl[12]),
    .stack_full(stack_full), .irq_accept(irq_accept), .irq_request(irq_request), .irq_vector(irq_vector),
    .wake_up(wake_up), .ext_irq_pin(ext_irq_pin), .tmr_a_overflow(pl[0]), .tmr_b_overflow(pl[1]),
    .usb_fifo_access(pl[2]), .usb_suspend(pl[3]), .usb_resume(pl[4]), .usb_bus_reset(pl[5]),
    .serial_a_done(pl[6]), .serial_b_done(pl[7]));
  csi_core_model i_core (.pclk(pclk), .presetn(presetn), .irq_request(irq_request), .stall(stall),
    .irq_accept(irq_accept));
  // ----
  // Tasks
  // ----
  task chk(input string what, input [11:0] exp, input [11:0] got);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      error_cnt = error_cnt + 1;
    end
  end
  endtask
  task apb(input wr, input [7:0] idx, input [7:0] wd);
  begin
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    chk("pready", 1, pready);
    chk("pslverr", 0, pslverr);
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  task pulse(input [12:0] m);
  begin
    pl <= m;
    @(posedge pclk);
    pl <= 13'h0;
    @(posedge pclk);
  end
  endtask
  task alu(input [2:0] op, input [7:0] a, input [7:0] b, input c, input w, input [7:0] er, input [7:0] m,
    input [7:0] ef);
  begin
    alu_op <= op;
    alu_a <= a;
    alu_b <= b;
    alu_cin <= c;
    alu_write_work <= w;
    alu_valid <= 1'b1;
    @(posedge pclk);
    alu_valid <= 1'b0;
    @(posedge pclk);
    chk("alu_result", er, alu_result);
    apb(0, `CSI_ADDR_FLAG, 0);
    chk("flags", ef, rd & m);
  end
  endtask
  task final_report;
  begin
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // ----
  // Clock, watchdog
  // ----
  initial
  begin
    forever #25 pclk = ~pclk;
  end
  initial
  begin
    #(50 * 20000);
    error_cnt = error_cnt + 1;
    final_report;
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    rows[0] = {8'h05, 8'ha5, 8'h05, 8'ha5};
    rows[1] = {8'h41, 8'h3c, 8'h41, 8'h3c};
    rows[2] = {8'h01, 8'h41, 8'h00, 8'h3c};
    rows[3] = {8'h03, 8'h41, 8'h02, 8'h3c};
    rows[4] = {8'h02, 8'h5a, 8'h41, 8'h5a};
    rows[5] = {8'h01, 8'h00, 8'h00, 8'h00};
    rows[6] = {8'h00, 8'h77, 8'h01, 8'h00};
    rows[7] = {8'h0a, 8'hff, 8'h0a, 8'h0f};
    rows[8] = {8'h0b, 8'h8e, 8'h0b, 8'h0e};
    rows[9] = {8'h1e, 8'h8f, 8'h1e, 8'h07};
    rows[10] = {8'h20, 8'hff, 8'h20, 8'h00};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `CSI_ADDR_FLAG, 0);
    chk("flag reset", 0, rd);
    apb(0, `CSI_ADDR_IRQ_A, 0);
    chk("irq_a reset", 0, rd);
    $display("done: reset");
    for (i = 0; i < 11; i = i + 1)
    begin
      apb(1, rows[i][31:24], rows[i][23:16]);
      apb(0, rows[i][15:8], 0);
      chk("row read", rows[i][7:0], rd);
    end
    $display("done: rows");
    alu(`CSI_ALU_ADD, 8'hff, 8'h01, 0, 0, 8'h00, 8'h0f, 8'h07);
    alu(`CSI_ALU_ADD, 8'h7f, 8'h01, 0, 0, 8'h80, 8'h0f, 8'h0a);
    alu(`CSI_ALU_SUB, 8'h50, 8'h30, 1, 0, 8'h20, 8'h0f, 8'h03);
    alu(`CSI_ALU_SUB, 8'h30, 8'h50, 1, 0, 8'he0, 8'h0f, 8'h02);
    alu(`CSI_ALU_RRC, 8'h01, 8'h01, 0, 0, 8'h00, 8'h01, 8'h01);
    alu(`CSI_ALU_RLC, 8'h80, 8'h80, 1, 0, 8'h01, 8'h01, 8'h01);
    alu(`CSI_ALU_LOGIC, 8'h00, 8'h3c, 0, 1, 8'h3c, 8'h04, 8'h00);
    apb(0, `CSI_ADDR_WORK, 0);
    chk("work", 8'h3c, rd);
    $display("done: alu");
    pulse(13'h0100);
    apb(0, `CSI_ADDR_FLAG, 0);
    chk("after sleep", 8'h10, rd & 8'h30);
    pulse(13'h0400);
    apb(1, `CSI_ADDR_FLAG, 0);
    apb(0, `CSI_ADDR_FLAG, 0);
    chk("after timeout", 8'h30, rd & 8'h30);
    pulse(13'h0200);
    pulse(13'h0400);
    pulse(13'h0100);
    apb(0, `CSI_ADDR_FLAG, 0);
    chk("kick then sleep", 8'h10, rd & 8'h30);
    $display("done: power flags");
    for (i = 2; i < 6; i = i + 1)
    begin
      pulse(13'h1 << i);
      apb(0, `CSI_ADDR_IRQ_B, 0);
      chk("usb flag", 8'h10, rd & 8'h10);
      apb(1, `CSI_ADDR_IRQ_B, 0);
    end
    $display("done: usb events");
    stack_full <= 1'b1;
    stall <= 4'h3;
    apb(1, `CSI_ADDR_IRQ_A, 8'h0f);
    apb(1, `CSI_ADDR_IRQ_B, 8'h07);
    ext_irq_pin <= 1'b0;
    pulse(13'h00c7);
    chk("stack full", 0, irq_request);
    chk("wake", 1, wake_up);
    apb(0, `CSI_ADDR_IRQ_A, 0);
    chk("irq_a flags", 8'h7f, rd);
    apb(0, `CSI_ADDR_IRQ_B, 0);
    chk("irq_b flags", 8'h77, rd);
    stack_full <= 1'b0;
    for (i = 0; i < 6; i = i + 1)
    begin
      n = 0;
      @(posedge pclk);
      while (!(irq_accept === 1'b1 && irq_request === 1'b1) && n < 40)
      begin
        n = n + 1;
        @(posedge pclk);
      end
      @(posedge pclk);
      chk("vector", 4 * (i + 1), irq_vector);
      chk("blocked", 0, irq_request);
      pulse(13'h1000);
      chk("sub exit", 0, irq_request);
      if (i % 2 == 0)
        pulse(13'h0800);
      else
      begin
        apb(0, `CSI_ADDR_IRQ_A, 0);
        apb(1, `CSI_ADDR_IRQ_A, rd | 8'h01);
      end
    end
    chk("all served", 0, wake_up);
    $display("done: interrupts");
    ext_irq_pin <= 1'b1;
    pulse(13'h0080);
    chk("wake before reset", 1, wake_up);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("vector reset", 0, irq_vector);
    chk("wake reset", 0, wake_up);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `CSI_ADDR_IRQ_B, 0);
    chk("irq_b reset", 0, rd);
    $display("done: mid-run reset");
    final_report;
  end
endmodule
